// >>> design/icp_irq_combiner.sv
/*
 * Paced interrupt combiner: merges twenty level sources into one
 * processor interrupt, gated by a global enable and a pacing counter,
 * plus a small status/enable/clear block for its own events.
 * Assumes synchronous source levels and a one-cycle strobe register port.
 */
`timescale 1ns/1ps
`default_nettype none
module icp_irq_combiner (
    input wire logic CORE_CLK_IN,
    input wire logic NRST_IN,
    // Register port
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [31:0] REG_RDATA_OUT,
    // Level sources
    input wire logic [7:0] TX_CHANNEL_DONE_IRQ_IN,
    input wire logic [7:0] RX_CHANNEL_DONE_IRQ_IN,
    input wire logic STATISTICS_OVERFLOW_IRQ_IN,
    input wire logic DESCRIPTOR_ERROR_IRQ_IN,
    input wire logic PHY_LINK_CHANGE_IRQ_IN,
    input wire logic MGMT_ACCESS_DONE_IRQ_IN,
    // Outputs
    output logic COMBINED_CPU_IRQ_OUT,
    output logic BLOCK_IRQ_OUT
);
    import icp_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    icp_pace_if pace ();

    logic global_irq_enable_r;
    logic global_irq_enable_nxt;
    logic [16:0] pace_cnt_r;
    logic [16:0] pace_cnt_nxt;
    logic [1:0] stat_r;
    logic [1:0] stat_nxt;
    logic [1:0] stat_en_r;
    logic [1:0] stat_en_nxt;
    logic [31:0] rdata_nxt;
    logic comb_irq_nxt;
    logic block_irq_nxt;
    logic pace_zero_d_r;
    icp_gate_t gate_r;
    icp_gate_t gate_nxt;

    wire [19:0] irq_cause_vector;
    wire any_src;
    wire wr_ctl;
    wire wr_pace;
    wire wr_en;
    wire wr_clr;
    wire enable_rise;
    wire irq_rise;
    wire pace_done;
    wire [1:0] clr_bits;
    wire gate_on;

    // ------------------------------------------------------------
    // Source merge
    // ------------------------------------------------------------
    // All twenty sources fold into one level; order matches the cause vector
    assign irq_cause_vector = {MGMT_ACCESS_DONE_IRQ_IN, PHY_LINK_CHANGE_IRQ_IN,
        DESCRIPTOR_ERROR_IRQ_IN, STATISTICS_OVERFLOW_IRQ_IN,
        RX_CHANNEL_DONE_IRQ_IN, TX_CHANNEL_DONE_IRQ_IN};
    assign any_src = |irq_cause_vector;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    assign wr_ctl = REG_WR_IN && (REG_ADDR_IN == ICP_ADDR_GATE_CTL);
    assign wr_pace = REG_WR_IN && (REG_ADDR_IN == ICP_ADDR_PACE_CNT);
    assign wr_en = REG_WR_IN && (REG_ADDR_IN == ICP_ADDR_IRQ_EN);
    assign wr_clr = REG_WR_IN && (REG_ADDR_IN == ICP_ADDR_IRQ_CLR);

    assign global_irq_enable_nxt = wr_ctl ? REG_WDATA_IN[ICP_ENABLE_BIT]
                                          : global_irq_enable_r;
    assign pace_cnt_nxt = wr_pace ? REG_WDATA_IN[ICP_PACE_W-1:0] : pace_cnt_r;
    assign stat_en_nxt = wr_en ? REG_WDATA_IN[ICP_STAT_W-1:0] : stat_en_r;

    // Only a 0 to 1 change reloads; rewriting 1 leaves pacing alone
    assign enable_rise = wr_ctl && REG_WDATA_IN[ICP_ENABLE_BIT]
                         && !global_irq_enable_r;

    // ------------------------------------------------------------
    // Pacing counter hookup
    // ------------------------------------------------------------
    assign pace.load = enable_rise;
    assign pace.load_val = pace_cnt_r;

    icp_tick_gen u_tick (
        .clk_in(CORE_CLK_IN),
        .nrst_in(NRST_IN),
        .tick_out(pace.tick)
    );

    icp_pace_ctr u_ctr (
        .clk_in(CORE_CLK_IN),
        .nrst_in(NRST_IN),
        .pace(pace.ctr)
    );

    // ------------------------------------------------------------
    // Gate state: off, pacing, armed
    // ------------------------------------------------------------
    // Tracks the enable and pacing situation; the output itself is decoded
    // below so a counter still running always blocks it
    always_comb begin
        gate_nxt = gate_r;
        case (gate_r)
            ICP_GATE_OFF: begin
                if (enable_rise) begin
                    gate_nxt = ICP_GATE_PACE;
                end
            end
            ICP_GATE_PACE: begin
                if (!global_irq_enable_nxt) begin
                    gate_nxt = ICP_GATE_OFF;
                end else if (pace.zero) begin
                    gate_nxt = ICP_GATE_ARMED;
                end
            end
            ICP_GATE_ARMED: begin
                if (!global_irq_enable_nxt) begin
                    gate_nxt = ICP_GATE_OFF;
                end
            end
            default: begin
                gate_nxt = ICP_GATE_OFF;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Combined output
    // ------------------------------------------------------------
    // Registered, so the output follows enable and sources one cycle later.
    // Dropping enable forces it low; re-enabling with pending sources and a
    // zero count raises it again, giving the processor a fresh edge.
    // The gate state leaves off together with the enable, so it adds no delay
    assign gate_on = (gate_r != ICP_GATE_OFF);
    assign comb_irq_nxt = global_irq_enable_r
                          && gate_on
                          && any_src
                          && pace.zero
                          && !enable_rise;

    // ------------------------------------------------------------
    // Own event status
    // ------------------------------------------------------------
    assign irq_rise = comb_irq_nxt && !COMBINED_CPU_IRQ_OUT;
    assign pace_done = pace.zero && !pace_zero_d_r;
    assign clr_bits = wr_clr ? REG_WDATA_IN[ICP_STAT_W-1:0] : 2'h0;
    // A new event wins over a clear written in the same cycle
    assign stat_nxt = (stat_r & ~clr_bits) | {pace_done, irq_rise};
    assign block_irq_nxt = |(stat_nxt & stat_en_nxt);

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Unmapped addresses and reserved bits read zero
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                ICP_ADDR_GATE_CTL: rdata_nxt = {31'h0, global_irq_enable_r};
                ICP_ADDR_PACE_CNT: rdata_nxt = {15'h0, pace_cnt_r};
                ICP_ADDR_IRQ_STAT: rdata_nxt = {30'h0, stat_r};
                ICP_ADDR_IRQ_EN: rdata_nxt = {30'h0, stat_en_r};
                ICP_ADDR_SRC_RAW: rdata_nxt = {12'h0, irq_cause_vector};
                ICP_ADDR_PACE_NOW: rdata_nxt = {15'h0, pace.count};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            global_irq_enable_r <= ICP_ENABLE_RST;
            pace_cnt_r <= ICP_PACE_RST;
            stat_r <= ICP_STAT_RST;
            stat_en_r <= ICP_STAT_RST;
            pace_zero_d_r <= 1'b1;
            gate_r <= ICP_GATE_OFF;
            REG_RDATA_OUT <= 32'h00000000;
            COMBINED_CPU_IRQ_OUT <= 1'b0;
            BLOCK_IRQ_OUT <= 1'b0;
        end else begin
            global_irq_enable_r <= global_irq_enable_nxt;
            pace_cnt_r <= pace_cnt_nxt;
            stat_r <= stat_nxt;
            stat_en_r <= stat_en_nxt;
            pace_zero_d_r <= pace.zero;
            gate_r <= gate_nxt;
            REG_RDATA_OUT <= rdata_nxt;
            COMBINED_CPU_IRQ_OUT <= comb_irq_nxt;
            BLOCK_IRQ_OUT <= block_irq_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> shared/icp_pkg.sv
/*
 * Constants for the paced interrupt combiner: register map, field layout,
 * reset values, pacing tick divisor and the interrupt status layout.
 * Assumes a single 250 MHz clock domain and a plain strobe register port.
 */
// Behaviour
// - Merge all twenty level source lines into one processor interrupt output.
// - Global enable at zero keeps the combined output low regardless of sources.
// - Enabled: output high when any source active and pacing counter is zero.
// - Re-enabling with sources still pending reasserts output, giving a new edge.
// - Each 0 to 1 enable change copies the programmed pacing count into the down-counter.
// - No further combined interrupt while the pacing counter is nonzero.
// - Pacing counter decrements once per tick at one sixth of system clock.
// - Pacing count field resets to zero, 17 bits wide, upper bits read zero.
// - Control register bit 0 is global enable, resets 0, bits 31..1 read zero.
// - Counter loads only on a 0 to 1 enable change, not on rewriting 1.

package icp_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ICP_ADDR_GATE_CTL = 8'h04;
    localparam logic [7:0] ICP_ADDR_PACE_CNT = 8'h08;
    localparam logic [7:0] ICP_ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ICP_ADDR_IRQ_EN = 8'h10;
    localparam logic [7:0] ICP_ADDR_IRQ_CLR = 8'h14;
    localparam logic [7:0] ICP_ADDR_SRC_RAW = 8'h18;
    localparam logic [7:0] ICP_ADDR_PACE_NOW = 8'h1c;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int ICP_ENABLE_BIT = 0;
    localparam int ICP_PACE_W = 17;
    localparam int ICP_SRC_W = 20;
    localparam logic ICP_ENABLE_RST = 1'b0;
    localparam logic [16:0] ICP_PACE_RST = 17'h00000;
    // Status bits: combined output rose, pacing counter expired
    localparam int ICP_STAT_W = 2;
    localparam int ICP_STAT_IRQ_ROSE = 0;
    localparam int ICP_STAT_PACE_DONE = 1;
    localparam logic [1:0] ICP_STAT_RST = 2'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int ICP_TICK_DIV = 6;
    localparam logic [2:0] ICP_TICK_LAST = 3'(ICP_TICK_DIV - 1);

    typedef enum logic [1:0] {
        ICP_GATE_OFF = 2'b00,
        ICP_GATE_PACE = 2'b01,
        ICP_GATE_ARMED = 2'b10
    } icp_gate_t;

endpackage

// >>> shared/icp_pace_if.sv
/*
 * Carrier between the top module and the pacing counter.
 * Assumes both ends run on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface icp_pace_if;
    logic load;
    logic [16:0] load_val;
    logic tick;
    logic [16:0] count;
    logic zero;

    modport ctrl (output load, output load_val, output tick, input count, input zero);
    modport ctr (input load, input load_val, input tick, output count, output zero);
endinterface
`default_nettype wire

// >>> design/icp_tick_gen.sv
/*
 * Divide-by-six tick generator for the pacing counter.
 * Assumes the core clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module icp_tick_gen (
    input wire logic clk_in,
    input wire logic nrst_in,
    output logic tick_out
);
    import icp_pkg::*;

    logic [2:0] div_r;
    logic [2:0] div_nxt;
    logic tick_nxt;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // One-cycle pulse every sixth cycle, free running
    assign tick_nxt = (div_r == ICP_TICK_LAST);
    assign div_nxt = tick_nxt ? 3'h0 : div_r + 3'h1;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_r <= 3'h0;
            tick_out <= 1'b0;
        end else begin
            div_r <= div_nxt;
            tick_out <= tick_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> design/icp_pace_ctr.sv
/*
 * Loadable 17-bit pacing down-counter, saturating at zero.
 * Assumes load and tick are single-cycle strobes from the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module icp_pace_ctr (
    input wire logic clk_in,
    input wire logic nrst_in,
    icp_pace_if.ctr pace
);
    import icp_pkg::*;

    logic [16:0] cnt_r;
    logic [16:0] cnt_nxt;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Load wins over tick so a fresh enable always starts full
    assign cnt_nxt = pace.load ? pace.load_val :
        (pace.tick && cnt_r != 17'h00000) ? cnt_r - 17'h00001 : cnt_r;
    assign pace.count = cnt_r;
    assign pace.zero = (cnt_r == 17'h00000);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_r <= ICP_PACE_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> verif/icp_irq_combiner_assertions.sv
/* Port-level checker for the paced interrupt combiner.
   Assumes it is bound onto icp_irq_combiner and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module icp_irq_combiner_assertions
import icp_pkg::*;
(
    input wire logic CORE_CLK_IN,
    input wire logic NRST_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [31:0] REG_RDATA_OUT,
    input wire logic [7:0] TX_CHANNEL_DONE_IRQ_IN,
    input wire logic [7:0] RX_CHANNEL_DONE_IRQ_IN,
    input wire logic STATISTICS_OVERFLOW_IRQ_IN,
    input wire logic DESCRIPTOR_ERROR_IRQ_IN,
    input wire logic PHY_LINK_CHANGE_IRQ_IN,
    input wire logic MGMT_ACCESS_DONE_IRQ_IN,
    input wire logic COMBINED_CPU_IRQ_OUT,
    input wire logic BLOCK_IRQ_OUT
);
    // ------------------------------------------------------------
    // Shadow of software state, rebuilt from the strobes
    // ------------------------------------------------------------
    logic en_sh_r;
    logic [16:0] pace_sh_r;
    wire logic any_src;
    wire logic wr_ctl;
    wire logic wr_pace;
    wire logic mapped;
    assign any_src = |{TX_CHANNEL_DONE_IRQ_IN, RX_CHANNEL_DONE_IRQ_IN, STATISTICS_OVERFLOW_IRQ_IN,
        DESCRIPTOR_ERROR_IRQ_IN, PHY_LINK_CHANGE_IRQ_IN, MGMT_ACCESS_DONE_IRQ_IN};
    assign wr_ctl = REG_WR_IN && REG_ADDR_IN == ICP_ADDR_GATE_CTL;
    assign wr_pace = REG_WR_IN && REG_ADDR_IN == ICP_ADDR_PACE_CNT;
    assign mapped = REG_ADDR_IN inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
    // Shadow follows the writes only, so it never copies a design slip
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            en_sh_r <= 1'b0;
            pace_sh_r <= 17'h00000;
        end else begin
            if (wr_ctl) en_sh_r <= REG_WDATA_IN[0];
            if (wr_pace) pace_sh_r <= REG_WDATA_IN[16:0];
        end
    end
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!NRST_IN);
    sequence s_arm;
        wr_ctl && REG_WDATA_IN[0] && !en_sh_r && pace_sh_r > 17'h00001;
    endsequence
    sequence s_reen;
        wr_ctl && REG_WDATA_IN[0] && !en_sh_r && pace_sh_r == 17'h00000;
    endsequence
    property p_off; !en_sh_r && !$past(en_sh_r) |-> !COMBINED_CPU_IRQ_OUT; endproperty
    a_off: assert property (p_off) else $error("output high while disabled");
    property p_rise; $rose(COMBINED_CPU_IRQ_OUT) |-> $past(en_sh_r); endproperty
    a_rise: assert property (p_rise) else $error("output rose without enable");
    property p_src; COMBINED_CPU_IRQ_OUT |-> $past(any_src); endproperty
    a_src: assert property (p_src) else $error("output high with no source");
    property p_hold; s_arm |-> ##1 !COMBINED_CPU_IRQ_OUT [*8]; endproperty
    a_hold: assert property (p_hold) else $error("output not held by pacing");
    property p_reen; s_reen ##1 (any_src && !REG_WR_IN) [*3] |-> COMBINED_CPU_IRQ_OUT; endproperty
    a_reen: assert property (p_reen) else $error("no new edge on re-enable");
    property p_ctl_rd;
        $past(REG_RD_IN && REG_ADDR_IN == ICP_ADDR_GATE_CTL)
            |-> REG_RDATA_OUT == {31'h0, $past(en_sh_r)};
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
    property p_pace_rd;
        $past(REG_RD_IN && REG_ADDR_IN == ICP_ADDR_PACE_CNT)
            |-> REG_RDATA_OUT == {15'h0, $past(pace_sh_r)};
    endproperty
    a_pace_rd: assert property (p_pace_rd) else $error("pacing count readback wrong");
    property p_unmap; $past(REG_RD_IN && !mapped) |-> REG_RDATA_OUT == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind icp_irq_combiner icp_irq_combiner_assertions chk_u (.CORE_CLK_IN, .NRST_IN, .REG_ADDR_IN,
    .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .TX_CHANNEL_DONE_IRQ_IN,
    .RX_CHANNEL_DONE_IRQ_IN, .STATISTICS_OVERFLOW_IRQ_IN, .DESCRIPTOR_ERROR_IRQ_IN,
    .PHY_LINK_CHANGE_IRQ_IN, .MGMT_ACCESS_DONE_IRQ_IN, .COMBINED_CPU_IRQ_OUT, .BLOCK_IRQ_OUT);
`default_nettype wire

// >>> verif/icp_edge_counter.sv
/* Processor-side model: an edge-triggered controller that counts rises.
   Assumes the core clock; level highs without a new rise go unseen. */
`timescale 1ns/1ps
`default_nettype none
module icp_edge_counter (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic irq_in,
    output logic [15:0] edges_out
);
    logic prev_r;
    // Only a rise counts, so a stuck level is a single interrupt
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prev_r <= 1'b0;
            edges_out <= 16'h0000;
        end else begin
            prev_r <= irq_in;
            if (irq_in && !prev_r) edges_out <= edges_out + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// >>> verif/icp_irq_combiner_tb.sv
/* Self-checking bench for the paced interrupt combiner.
   Assumes the bound checker and the edge-counting processor model. */
`timescale 1ns/1ps
`default_nettype none
module icp_irq_combiner_tb;
    import icp_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, cpu_irq, blk_irq;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d, v1;
    logic [19:0] src = 20'h0;
    logic [15:0] edges, e0;
    int seed = 39, bad_count = 0, n_tests = 0, cyc;
    initial forever #2 clk = ~clk;
    icp_irq_combiner dut_u (.CORE_CLK_IN(clk), .NRST_IN(nrst), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .TX_CHANNEL_DONE_IRQ_IN(src[7:0]), .RX_CHANNEL_DONE_IRQ_IN(src[15:8]),
        .STATISTICS_OVERFLOW_IRQ_IN(src[16]), .DESCRIPTOR_ERROR_IRQ_IN(src[17]),
        .PHY_LINK_CHANGE_IRQ_IN(src[18]), .MGMT_ACCESS_DONE_IRQ_IN(src[19]),
        .COMBINED_CPU_IRQ_OUT(cpu_irq), .BLOCK_IRQ_OUT(blk_irq));
    icp_edge_counter edge_u (.clk_in(clk), .nrst_in(nrst), .irq_in(cpu_irq), .edges_out(edges));
    // ------------------------------------------------------------
    // Bus cycles, comparison and expectations
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // Saturating countdown: the counter holds at zero
    function automatic logic [31:0] exp_live(logic [31:0] n, int ticks);
        return (n > 32'(ticks)) ? n - 32'(ticks) : 32'h0;
    endfunction
    task report_and_stop;
        if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        report_and_stop;
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(ICP_ADDR_GATE_CTL, d); chk(d, 32'h0);
        rd_reg(ICP_ADDR_PACE_CNT, d); chk(d, 32'h0);
        wr_reg(ICP_ADDR_GATE_CTL, 32'hffffffff);
        rd_reg(ICP_ADDR_GATE_CTL, d);
        chk(d, 32'h1);
        wr_reg(ICP_ADDR_PACE_CNT, 32'hffffffff);
        rd_reg(ICP_ADDR_PACE_CNT, d);
        chk(d, 32'h1ffff);
        wr_reg(ICP_ADDR_PACE_CNT, 32'h0);
        wr_reg(ICP_ADDR_GATE_CTL, 32'h0);
        // Each line alone, then random mixes, serviced the way a handler would
        for (int i = 0; i < 40; i++) begin
            e0 = edges;
            src <= (i < 20) ? 20'h1 << i : 20'($random(seed));
            wr_reg(ICP_ADDR_GATE_CTL, 32'h1); repeat (4) @(posedge clk);
            chk(32'(cpu_irq), 32'(|src));
            chk(32'(edges - e0), 32'(|src));
            wr_reg(ICP_ADDR_GATE_CTL, 32'h0); repeat (3) @(posedge clk);
            chk(32'(cpu_irq), 32'h0);
        end
        // Count of 3 holds the output back for three ticks; the first tick
        // lands 1 to 6 cycles after the load, the output one cycle after zero
        src <= 20'h40000;
        wr_reg(ICP_ADDR_PACE_CNT, 32'h3); wr_reg(ICP_ADDR_GATE_CTL, 32'h1);
        cyc = 0;
        while (cpu_irq !== 1'b1 && cyc < 40) begin
            @(posedge clk); #1 cyc++;
        end
        chk(32'(cyc >= 6 * 2 + 2 && cyc <= 6 * 3 + 1), 32'h1);
        wr_reg(ICP_ADDR_GATE_CTL, 32'h0);
        // Live counter: load, rewrite of 1, countdown and hold at zero
        wr_reg(ICP_ADDR_PACE_CNT, 32'h28);
        wr_reg(ICP_ADDR_GATE_CTL, 32'h1);
        @(posedge clk);
        rd_reg(ICP_ADDR_PACE_NOW, d);
        chk(d, 32'h28);
        rd_reg(ICP_ADDR_PACE_NOW, v1);
        wr_reg(ICP_ADDR_GATE_CTL, 32'h1); repeat (56) @(posedge clk);
        rd_reg(ICP_ADDR_PACE_NOW, d); chk(d, exp_live(v1, 10));
        repeat (300) @(posedge clk);
        rd_reg(ICP_ADDR_PACE_NOW, d); chk(d, 32'h0);
        chk(32'(cpu_irq), 32'h1);
        // Block status interrupt: sticky, masked, enabled, cleared
        wr_reg(ICP_ADDR_GATE_CTL, 32'h0); repeat (3) @(posedge clk);
        rd_reg(ICP_ADDR_IRQ_STAT, d);
        chk(d & 32'h3, 32'h3);
        chk(32'(blk_irq), 32'h0);
        wr_reg(ICP_ADDR_IRQ_EN, 32'h1); repeat (2) @(posedge clk);
        chk(32'(blk_irq), 32'h1);
        wr_reg(ICP_ADDR_IRQ_CLR, 32'h1); repeat (2) @(posedge clk);
        chk(32'(blk_irq), 32'h0);
        rd_reg(ICP_ADDR_IRQ_STAT, d); chk(d & 32'h1, 32'h0);
        rd_reg(ICP_ADDR_IRQ_CLR, d); chk(d, 32'h0);
        rd_reg(ICP_ADDR_SRC_RAW, d); chk(d, 32'(src));
        wr_reg(8'h20, 32'hffffffff); rd_reg(8'h20, d); chk(d, 32'h0);
        report_and_stop;
    end
endmodule
`default_nettype wire
